// File: src/cctc_top.v
// Control and status slice of an eight-channel 16-bit capture/compare timer.
// Assumes a byte-wide register port, synchronous pin inputs, one clock.
// What this block does
// - Direction bit: 0 capture, 1 compare.
// - Force register always reads zero.
// - Force bit performs compare action, no flag.
// - Ch7 mask drives compare pin as output.
// - Ch7 match copies ch7 data to masked pins.
// - Ch7 mask blocks channel mode/level action.
// - Simultaneous match: ch7 data wins on pin.
// - 16-bit up counter; writes only while special_mode_select_in low.
// - Counter write not synchronised with prescaler.
// - Run bit 0 halts counter and div64.
// - Halt in wait stops timer, accumulators, modulus.
// - Halt in debug stops timer and modulus only.
// - Quick clear: capture read/compare write clears flag.
// - Quick clear: counter accesses clear their flags.
// - Mode/level: off, toggle, clear, set.
// - Mode or level set makes compare pin output.
// - Edge bits: off, rising, falling, any.
// - Channel enable gates channel flag to irq.
// - Wrap enable gates wrap flag to irq.
// - Pins are GPIO until compare takes them.
// - Port data latched while timer owns pin.
// - Wrap flag set on wrap, cleared by bit 7.
// - Channel flags cleared by writing one.
// - Prescale 2^n, changes when stages zero.
// - Counter clear on ch7 match when enabled.
`include "cctc_defs.vh"
module cctc_top #(
	parameter CH_N = 8
) (
	// Clock and reset.
	input  wire                    clk_in,
	input  wire                    rstn_in,
	// Register port.
	input  wire [`CCTC_ADDR_W-1:0] addr_in,
	input  wire [7:0]              wdata_in,
	input  wire                    wr_in,
	input  wire                    rd_in,
	output reg  [7:0]              rdata_out,
	// Processor state.
	input  wire                    special_mode_select_in,
	input  wire                    cpu_wait_in,
	input  wire                    cpu_debug_in,
	// Timer port pins.
	input  wire [CH_N-1:0]         pin_in,
	output reg  [CH_N-1:0]         pin_out,
	output reg  [CH_N-1:0]         pin_oe_out,
	// Requests and clocks to neighbouring timer parts.
	output wire                    irq_out,
	output wire                    div64_tick_out,
	output wire                    accum_run_out,
	output wire                    modulus_run_out,
	output wire                    accum_a_clear_out,
	output wire                    accum_b_clear_out,
	output wire                    modulus_clear_out
);

	reg [7:0]  func_sel_q, c7_mask_q, c7_data_q, sys_ctrl_q, out_hi_q, out_lo_q;
	reg [7:0]  edge_hi_q, edge_lo_q, irq_en_q, ovf_ctrl_q, port_data_q, port_dir_q;
	reg [7:0]  ch_flag_q, oc_line_q, pin_prev_q;
	reg [15:0] cnt_q;
	reg [15:0] cmp_q [0:CH_N-1];
	reg [15:0] cap_q [0:CH_N-1];
	reg [6:0]  presc_q;
	reg [2:0]  presc_sel_q;
	reg        wrap_flag_q;
	reg        wr_d1_q;
	integer    i;
	integer    j;
	integer    k;
	integer    m;

	// Two-bit field of channel n within a pair of control bytes.
	function [1:0] pair_of;
		input [7:0] hi;
		input [7:0] lo;
		input [2:0] n;
		reg   [15:0] both;
		begin
			both = {hi, lo};
			pair_of = both[{n, 1'b0} +: 2];
		end
	endfunction

	// Run gating from enable, wait and debug.
	wire halt_wait = sys_ctrl_q[`CCTC_BIT_HALT_WAIT] & cpu_wait_in;
	wire halt_dbg  = sys_ctrl_q[`CCTC_BIT_HALT_DBG] & cpu_debug_in;
	wire run       = sys_ctrl_q[`CCTC_BIT_RUN] & ~halt_wait & ~halt_dbg;
	assign accum_run_out   = ~halt_wait;
	assign modulus_run_out = ~halt_wait & ~halt_dbg;

	// Prescaler: divide by 2^sel; a new setting loads once all stages are zero.
	wire [6:0] presc_mask = (7'h01 << presc_sel_q) - 7'h01;
	wire       cnt_tick   = run & ((presc_q & presc_mask) == 7'h00);
	assign div64_tick_out = run & (presc_q[`CCTC_DIV64_LOG2-1:0] == 6'h00);

	// Access decode.
	wire quick   = sys_ctrl_q[`CCTC_BIT_QUICK_CLR];
	wire acc     = wr_in | rd_in;
	wire cnt_acc = acc & ((addr_in == `CCTC_OFS_CNT_HI) | (addr_in == `CCTC_OFS_CNT_LO));
	wire cmp_win = (addr_in[7:4] == `CCTC_OFS_CMP_BASE >> 4);
	wire [2:0] cmp_ch = addr_in[3:1];
	assign accum_a_clear_out = quick & acc & ((addr_in == `CCTC_OFS_ACC_A_HI) |
		(addr_in == `CCTC_OFS_ACC_A_LO));
	assign accum_b_clear_out = quick & acc & ((addr_in == `CCTC_OFS_ACC_B_HI) |
		(addr_in == `CCTC_OFS_ACC_B_LO));
	assign modulus_clear_out = quick & acc & ((addr_in == `CCTC_OFS_MOD_HI) |
		(addr_in == `CCTC_OFS_MOD_LO));

	// Matches, forced actions and captures.
	reg [7:0] match, force_v, capt, act_hit;
	reg [1:0] es;
	always @* begin
		force_v = (wr_in && addr_in == `CCTC_OFS_FORCE) ? wdata_in : 8'h00;
		match = 8'h00;
		capt = 8'h00;
		es = 2'b00;
		for (j = 0; j < CH_N; j = j + 1) begin
			match[j] = cnt_tick & func_sel_q[j] & (cnt_q == cmp_q[j]);
			es = pair_of(edge_hi_q, edge_lo_q, j[2:0]);
			capt[j] = ~func_sel_q[j] & ((es[0] & ~pin_prev_q[j] & pin_in[j]) |
				(es[1] & pin_prev_q[j] & ~pin_in[j]));
		end
		act_hit = match | (force_v & func_sel_q);
	end
	wire c7_fire = act_hit[7];

	// Output compare line per channel; ch7 mask overrides the channel action.
	reg [7:0] oc_next;
	reg [1:0] ml;
	always @* begin
		ml = 2'b00;
		for (k = 0; k < CH_N; k = k + 1) begin
			ml = pair_of(out_hi_q, out_lo_q, k[2:0]);
			oc_next[k] = oc_line_q[k];
			if (c7_mask_q[k]) begin
				if (c7_fire)
					oc_next[k] = c7_data_q[k];
			end else if (act_hit[k]) begin
				case (ml)
					2'b01: oc_next[k] = ~oc_line_q[k];
					2'b10: oc_next[k] = 1'b0;
					2'b11: oc_next[k] = 1'b1;
					default: oc_next[k] = oc_line_q[k];
				endcase
			end
		end
	end

	// Pin ownership: compare function takes the pin, else general I/O.
	reg       timer_own;
	reg [1:0] own_ml;
	always @* begin
		timer_own = 1'b0;
		own_ml = 2'b00;
		for (m = 0; m < CH_N; m = m + 1) begin
			own_ml = pair_of(out_hi_q, out_lo_q, m[2:0]);
			timer_own = func_sel_q[m] & (c7_mask_q[m] | (own_ml != 2'b00));
			pin_oe_out[m] = timer_own | port_dir_q[m];
			pin_out[m] = timer_own ? oc_line_q[m] : port_data_q[m];
		end
	end

	// Interrupt request from gated flags.
	assign irq_out = |(ch_flag_q & irq_en_q) | (wrap_flag_q & ovf_ctrl_q[`CCTC_BIT_WRAP_IE]);

	// Channel flag next value: events set, clears by write-one or quick clear.
	reg [7:0] flag_clr, flag_set;
	always @* begin
		flag_clr = 8'h00;
		if (wr_in && addr_in == `CCTC_OFS_CH_FLAG)
			flag_clr = wdata_in;
		if (quick && cmp_win && ((rd_in && !func_sel_q[cmp_ch]) ||
			(wr_in && func_sel_q[cmp_ch])))
			flag_clr[cmp_ch] = 1'b1;
		flag_set = match | capt;
	end

	// Main sequential process.
	always @(posedge clk_in) begin
		if (!rstn_in) begin
			func_sel_q  <= `CCTC_RST_BYTE;
			c7_mask_q   <= `CCTC_RST_BYTE;
			c7_data_q   <= `CCTC_RST_BYTE;
			sys_ctrl_q  <= `CCTC_RST_BYTE;
			out_hi_q    <= `CCTC_RST_BYTE;
			out_lo_q    <= `CCTC_RST_BYTE;
			edge_hi_q   <= `CCTC_RST_BYTE;
			edge_lo_q   <= `CCTC_RST_BYTE;
			irq_en_q    <= `CCTC_RST_BYTE;
			ovf_ctrl_q  <= `CCTC_RST_BYTE;
			port_data_q <= `CCTC_RST_BYTE;
			port_dir_q  <= `CCTC_RST_BYTE;
			ch_flag_q   <= `CCTC_RST_BYTE;
			oc_line_q   <= `CCTC_RST_BYTE;
			pin_prev_q  <= `CCTC_RST_BYTE;
			cnt_q       <= `CCTC_RST_WORD;
			presc_q     <= 7'h00;
			presc_sel_q <= 3'h0;
			wrap_flag_q <= 1'b0;
			wr_d1_q     <= 1'b0;
			rdata_out   <= `CCTC_RST_BYTE;
			for (i = 0; i < CH_N; i = i + 1) begin
				cmp_q[i] <= `CCTC_RST_WORD;
				cap_q[i] <= `CCTC_RST_WORD;
			end
		end else begin
			wr_d1_q    <= wr_in;
			pin_prev_q <= pin_in;
			oc_line_q  <= oc_next;
			ch_flag_q  <= (ch_flag_q & ~flag_clr) | flag_set;
			// Prescaler runs only while the timer runs.
			if (run)
				presc_q <= presc_q + 7'h01;
			if (presc_q == 7'h00)
				presc_sel_q <= ovf_ctrl_q[2:0];
			// Counter: wrap flag, clear on ch7, write while special_mode_select_in low.
			if (cnt_tick) begin
				if (c7_fire && ovf_ctrl_q[`CCTC_BIT_CLR_ON_C7])
					cnt_q <= `CCTC_RST_WORD;
				else
					cnt_q <= cnt_q + 16'h0001;
			end
			if (wr_in && !special_mode_select_in && addr_in == `CCTC_OFS_CNT_HI)
				cnt_q[15:8] <= wdata_in;
			if (wr_in && !special_mode_select_in && addr_in == `CCTC_OFS_CNT_LO)
				cnt_q[7:0] <= wdata_in;
			if ((wr_in && addr_in == `CCTC_OFS_WRAP_FLAG && wdata_in[`CCTC_BIT_WRAP_FLAG]) ||
				(quick && cnt_acc))
				wrap_flag_q <= 1'b0;
			if (cnt_tick && cnt_q == 16'hFFFF &&
				!(c7_fire && ovf_ctrl_q[`CCTC_BIT_CLR_ON_C7]))
				wrap_flag_q <= 1'b1;
			// Captures.
			for (i = 0; i < CH_N; i = i + 1)
				if (capt[i])
					cap_q[i] <= cnt_q;
			// Register writes.
			if (wr_in) begin
				case (addr_in)
					`CCTC_OFS_FUNC_SEL:  func_sel_q  <= wdata_in;
					`CCTC_OFS_C7_MASK:   c7_mask_q   <= wdata_in;
					`CCTC_OFS_C7_DATA:   c7_data_q   <= wdata_in;
					`CCTC_OFS_SYS_CTRL:  sys_ctrl_q  <= {wdata_in[7:4], 4'h0};
					`CCTC_OFS_OUT_HI:    out_hi_q    <= wdata_in;
					`CCTC_OFS_OUT_LO:    out_lo_q    <= wdata_in;
					`CCTC_OFS_EDGE_HI:   edge_hi_q   <= wdata_in;
					`CCTC_OFS_EDGE_LO:   edge_lo_q   <= wdata_in;
					`CCTC_OFS_IRQ_EN:    irq_en_q    <= wdata_in;
					`CCTC_OFS_OVF_CTRL:  ovf_ctrl_q  <= {wdata_in[7], 1'b0, wdata_in[5:0]};
					`CCTC_OFS_PORT_DATA: port_data_q <= wdata_in;
					`CCTC_OFS_PORT_DIR:  port_dir_q  <= wdata_in;
					default: ;
				endcase
				if (cmp_win) begin
					if (addr_in[0])
						cmp_q[cmp_ch][7:0] <= wdata_in;
					else
						cmp_q[cmp_ch][15:8] <= wdata_in;
				end
			end
			// Read data, valid the cycle after the strobe.
			rdata_out <= 8'h00;
			if (rd_in) begin
				case (addr_in)
					`CCTC_OFS_FUNC_SEL:  rdata_out <= func_sel_q;
					`CCTC_OFS_FORCE:     rdata_out <= 8'h00;
					`CCTC_OFS_C7_MASK:   rdata_out <= c7_mask_q;
					`CCTC_OFS_C7_DATA:   rdata_out <= c7_data_q;
					`CCTC_OFS_CNT_HI:    rdata_out <= cnt_q[15:8];
					`CCTC_OFS_CNT_LO:    rdata_out <= cnt_q[7:0];
					`CCTC_OFS_SYS_CTRL:  rdata_out <= sys_ctrl_q;
					`CCTC_OFS_OUT_HI:    rdata_out <= out_hi_q;
					`CCTC_OFS_OUT_LO:    rdata_out <= out_lo_q;
					`CCTC_OFS_EDGE_HI:   rdata_out <= edge_hi_q;
					`CCTC_OFS_EDGE_LO:   rdata_out <= edge_lo_q;
					`CCTC_OFS_IRQ_EN:    rdata_out <= irq_en_q;
					`CCTC_OFS_OVF_CTRL:  rdata_out <= ovf_ctrl_q;
					`CCTC_OFS_CH_FLAG:   rdata_out <= ch_flag_q;
					`CCTC_OFS_WRAP_FLAG: rdata_out <= {wrap_flag_q, 7'h00};
					`CCTC_OFS_PORT_DATA: rdata_out <= port_data_q;
					`CCTC_OFS_PORT_DIR:  rdata_out <= port_dir_q;
					default: begin
						if (cmp_win)
							rdata_out <= func_sel_q[cmp_ch] ?
								(addr_in[0] ? cmp_q[cmp_ch][7:0] : cmp_q[cmp_ch][15:8]) :
								(addr_in[0] ? cap_q[cmp_ch][7:0] : cap_q[cmp_ch][15:8]);
					end
				endcase
			end
		end
	end

endmodule // cctc_top

// File: src/cctc_defs.vh
// Register map and field positions of the capture/compare timer controls.
// Assumes an 8-bit register port with byte offsets as listed below.
`ifndef CCTC_DEFS_VH
`define CCTC_DEFS_VH
`define CCTC_ADDR_W        8
`define CCTC_OFS_FUNC_SEL  8'h80
`define CCTC_OFS_FORCE     8'h81
`define CCTC_OFS_C7_MASK   8'h82
`define CCTC_OFS_C7_DATA   8'h83
`define CCTC_OFS_CNT_HI    8'h84
`define CCTC_OFS_CNT_LO    8'h85
`define CCTC_OFS_SYS_CTRL  8'h86
`define CCTC_OFS_OUT_HI    8'h88
`define CCTC_OFS_OUT_LO    8'h89
`define CCTC_OFS_EDGE_HI   8'h8A
`define CCTC_OFS_EDGE_LO   8'h8B
`define CCTC_OFS_IRQ_EN    8'h8C
`define CCTC_OFS_OVF_CTRL  8'h8D
`define CCTC_OFS_CH_FLAG   8'h8E
`define CCTC_OFS_WRAP_FLAG 8'h8F
`define CCTC_OFS_CMP_BASE  8'h90
`define CCTC_OFS_PORT_DATA 8'hAE
`define CCTC_OFS_PORT_DIR  8'hAF
`define CCTC_OFS_ACC_A_HI  8'hA2
`define CCTC_OFS_ACC_A_LO  8'hA3
`define CCTC_OFS_ACC_B_HI  8'hA4
`define CCTC_OFS_ACC_B_LO  8'hA5
`define CCTC_OFS_MOD_HI    8'hB6
`define CCTC_OFS_MOD_LO    8'hB7
`define CCTC_BIT_RUN       7
`define CCTC_BIT_HALT_WAIT 6
`define CCTC_BIT_HALT_DBG  5
`define CCTC_BIT_QUICK_CLR 4
`define CCTC_BIT_WRAP_IE   7
`define CCTC_BIT_CLR_ON_C7 3
`define CCTC_BIT_WRAP_FLAG 7
`define CCTC_RST_BYTE      8'h00
`define CCTC_RST_WORD      16'h0000
`define CCTC_DIV64_LOG2    6
`endif

// File: verification/cctc_pin_model.sv
// Model of the circuitry outside the timer port pins.
// Assumes a drive enable is high while the slice drives that pin.
module cctc_pin_model (
	input  logic [7:0] pin_out,
	input  logic [7:0] pin_oe_out,
	input  logic [7:0] ext_in,
	output logic [7:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// A driven pin reads back its own level, an undriven one follows the outside world.
	assign pin_in = (pin_oe_out & pin_out) | (~pin_oe_out & ext_in);
endmodule // cctc_pin_model

// File: verification/cctc_top_assertions.sv
// Checker for the timer control slice, watching the ports of cctc_top only.
// Assumes writes land on the edge that takes them and a synchronous active-low reset.
module cctc_checker (
	input logic       clk_in,
	input logic       rstn_in,
	input logic [7:0] addr_in,
	input logic [7:0] wdata_in,
	input logic       wr_in,
	input logic       rd_in,
	input logic [7:0] rdata_out,
	input logic       cpu_wait_in,
	input logic       cpu_debug_in,
	input logic [7:0] pin_oe_out,
	input logic       div64_tick_out,
	input logic       accum_run_out,
	input logic       modulus_run_out,
	input logic       accum_a_clear_out,
	input logic       accum_b_clear_out,
	input logic       modulus_clear_out
);
	logic [7:0]  fs_q, mk_q, sc_q, dr_q, own;
	logic [15:0] oa_q;
	// Shadow copies of the registers that steer the pins and the clocks.
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			{fs_q, mk_q, sc_q, dr_q, oa_q} <= '0;
		end else if (wr_in) begin
			case (addr_in)
				8'h80: fs_q <= wdata_in;
				8'h82: mk_q <= wdata_in;
				8'h86: sc_q <= wdata_in;
				8'hAF: dr_q <= wdata_in;
				8'h88: oa_q[15:8] <= wdata_in;
				8'h89: oa_q[7:0] <= wdata_in;
				default: ;
			endcase
		end
	end
	// A compare channel owns its pin through the channel-7 mask or a nonzero action.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			own[i] = fs_q[i] & (mk_q[i] | (|oa_q[2*i+:2]));
		end
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	a_force_reads_zero: assert property (rd_in && addr_in == 8'h81 |=> rdata_out == 8'h00)
		else $error("force register read back nonzero");
	a_pin_drive_owner: assert property (pin_oe_out == (dr_q | own))
		else $error("pin drive enable does not match ownership");
	a_halt_no_tick: assert property (!sc_q[7] && !$past(sc_q[7]) |-> !div64_tick_out)
		else $error("divide-by-64 tick while timer stopped");
	a_tick_spacing: assert property (div64_tick_out |=> !div64_tick_out [*8])
		else $error("divide-by-64 ticks too close");
	a_wait_halts_accum: assert property (sc_q[6] && cpu_wait_in && $past(sc_q[6])
		&& $past(cpu_wait_in) |-> !accum_run_out) else $error("accumulators run in wait");
	a_debug_keeps_accum: assert property ($past(rstn_in) && !cpu_wait_in
		&& !$past(cpu_wait_in) |-> accum_run_out) else $error("accumulators stopped");
	a_debug_halts_mod: assert property (sc_q[5] && cpu_debug_in && $past(sc_q[5])
		&& $past(cpu_debug_in) |-> !modulus_run_out) else $error("modulus runs in debug");
	a_quick_clear_acc: assert property (accum_a_clear_out ==
		(sc_q[4] && (rd_in || wr_in) && addr_in[7:1] == 7'h51)) else $error("bad quick clear");
	a_quick_clear_accb: assert property (accum_b_clear_out ==
		(sc_q[4] && (rd_in || wr_in) && addr_in[7:1] == 7'h52)) else $error("bad clear b");
	a_quick_clear_mod: assert property (modulus_clear_out ==
		(sc_q[4] && (rd_in || wr_in) && addr_in[7:1] == 7'h5B)) else $error("bad clear mod");
endmodule // cctc_checker

bind cctc_top cctc_checker u_cctc_checker (
	.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
	.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .cpu_wait_in(cpu_wait_in),
	.cpu_debug_in(cpu_debug_in), .pin_oe_out(pin_oe_out), .div64_tick_out(div64_tick_out),
	.accum_run_out(accum_run_out), .modulus_run_out(modulus_run_out),
	.accum_a_clear_out(accum_a_clear_out), .accum_b_clear_out(accum_b_clear_out),
	.modulus_clear_out(modulus_clear_out)
);

// File: verification/cctc_top_tb.sv
// Self-checking bench for the capture/compare timer control slice.
// Assumes cctc_top, its bound checker and the pin model are compiled first.
module cctc_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 1'b0, rstn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, irq;
	logic smode = 1'b1, cwait = 1'b0, cdbg = 1'b0;
	logic [7:0] addr_in = '0, wdata_in = '0, ext = '0, pin_in, pin_out, pin_oe, rdata, d, v;
	logic [7:0] mdl [logic [7:0]];
	logic [7:0] regs [9] = '{8'h80, 8'h82, 8'h83, 8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'hAF};
	// Register write, then expected drive enables and driven levels.
	logic [31:0] ft [14] = '{32'h80FF_0000, 32'h8939_0700, 32'h810F_0705, 32'h810F_0704,
		32'h8204_0704, 32'h8180_0700, 32'h8104_0700, 32'h8304_0700, 32'h8180_0704,
		32'h8300_0704, 32'h8184_0700, 32'hAE02_0700, 32'hAF02_0700, 32'h8900_0602};
	int err_count = 0, tests_run = 0;
	cctc_top DUT (
		.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata), .special_mode_select_in(smode),
		.cpu_wait_in(cwait), .cpu_debug_in(cdbg), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe_out(pin_oe), .irq_out(irq), .div64_tick_out(), .accum_run_out(),
		.modulus_run_out(), .accum_a_clear_out(), .accum_b_clear_out(), .modulus_clear_out()
	);
	cctc_pin_model u_pins (.pin_out(pin_out), .pin_oe_out(pin_oe), .ext_in(ext), .pin_in(pin_in));
	// One write cycle on the register port.
	task automatic wr(input logic [7:0] a, input logic [7:0] x);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= x;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
		#1;
	endtask
	// One read cycle; the data is taken in the cycle after the strobe.
	task automatic rd(input logic [7:0] a);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		d = rdata;
	endtask
	// Compares one byte and reports a mismatch at once.
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Prints the verdict and ends the run.
	task automatic finish_test();
		if (err_count == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// The clock and the watchdog.
	initial forever #5 clk_in = ~clk_in;
	initial begin
		#50000;
		err_count++;
		finish_test();
	end
	// Main sequence: registers, forced actions, counter, captures.
	initial begin
		v = 8'($urandom(1699));
		repeat (6) @(posedge clk_in);
		rstn_in <= 1'b1;
		foreach (regs[i]) begin
			rd(regs[i]);
			chk(d, 8'h00);
		end
		repeat (2) begin
			foreach (regs[i]) begin
				v = 8'($urandom);
				mdl[regs[i]] = v;
				wr(regs[i], v);
			end
			foreach (regs[i]) begin
				rd(regs[i]);
				chk(d, mdl[regs[i]]);
			end
		end
		wr(8'h81, 8'hFF);
		rd(8'h81);
		chk(d, 8'h00);
		foreach (regs[i]) wr(regs[i], 8'h00);
		foreach (ft[i]) begin
			wr(ft[i][31:24], ft[i][23:16]);
			chk(pin_oe, ft[i][15:8]);
			chk(pin_out & pin_oe, ft[i][7:0]);
		end
		rd(8'h8E);
		chk(d, 8'h00);
		wr(8'h84, 8'h12);
		rd(8'h84);
		chk(d, 8'h00);
		smode <= 1'b0;
		wr(8'h84, 8'hFF);
		wr(8'h85, 8'hF0);
		rd(8'h84);
		chk(d, 8'hFF);
		wr(8'h8D, 8'h80);
		wr(8'h86, 8'hF0);
		cwait <= 1'b1;
		repeat (4) @(posedge clk_in);
		cwait <= 1'b0;
		cdbg <= 1'b1;
		repeat (4) @(posedge clk_in);
		cdbg <= 1'b0;
		repeat (200) @(posedge clk_in);
		wr(8'h86, 8'h10);
		rd(8'h8F);
		chk(d, 8'h80);
		chk({7'h00, irq}, 8'h01);
		rd(8'hA2);
		rd(8'h85);
		rd(8'h8F);
		chk(d, 8'h00);
		chk({7'h00, irq}, 8'h00);
		wr(8'h80, 8'h00);
		wr(8'h86, 8'h80);
		wr(8'h8E, 8'hFF);
		wr(8'h8B, 8'h01);
		wr(8'h8C, 8'h01);
		ext <= 8'h01;
		repeat (4) @(posedge clk_in);
		rd(8'h8E);
		chk(d, 8'h01);
		chk({7'h00, irq}, 8'h01);
		wr(8'h8E, 8'h00);
		rd(8'h8E);
		chk(d, 8'h01);
		wr(8'h8E, 8'h01);
		ext <= 8'h00;
		repeat (4) @(posedge clk_in);
		rd(8'h8E);
		chk(d, 8'h00);
		finish_test();
	end
endmodule // cctc_top_tb
